//--- bench/testbench.sv
// testbench: directed scenarios for the watchdog timer block
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic              sys_clk           = 1'b0;
  logic              reset_n           = 1'b0;
  logic              external_init_pin = 1'b1;
  logic              rc_osc_clk        = 1'b0;
  wdt_pkg::wdt_opt_t opt               = 3'h6;
  wdt_pkg::wdt_cmd_t cmd               = 4'h0;
  logic              sleeping          = 1'b0;
  logic [7:0]        reg_addr          = 8'h00;
  logic [7:0]        reg_wdata         = 8'h00;
  logic              reg_write         = 1'b0;
  logic              reg_read          = 1'b0;
  logic [7:0]        reg_rdata;
  logic              chip_reset;
  logic              warm_reset;
  logic              irq;
  logic [1:0]        rc_div            = 2'h0;
  int                num_errors        = 0;
  int                checks_done       = 0;
  int                n;

  watchdog_timer i_watchdog_timer (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .external_init_pin(external_init_pin), .rc_osc_clk(rc_osc_clk),
    .opt(opt), .cmd(cmd), .sleeping(sleeping),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .chip_reset(chip_reset), .warm_reset(warm_reset), .irq(irq));

  // clock; the rc oscillator runs free at a quarter of it, as on chip
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    rc_div     <= rc_div + 2'h1;
    rc_osc_clk <= rc_div[1];
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic pulse(input wdt_pkg::wdt_cmd_t c);
    @(posedge sys_clk);
    cmd <= c;
    @(posedge sys_clk);
    cmd <= 4'h0;
  endtask
  // counts cycles until either reset pulse, bounded by lim
  task automatic run(input int lim);
    n = 0;
    while (n < lim && chip_reset !== 1'b1 && warm_reset !== 1'b1) begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask
  task automatic quiet(input int lim);
    run(lim);
    chk({6'h0, chip_reset, warm_reset}, 8'h00);
  endtask
  // e is the expected cycle count; sync delay gives some slack
  task automatic expect_to(input int e, input logic [7:0] kind);
    run(e + 12);
    chk(8'(n >= e - 6 && n <= e + 12), 8'h01);
    chk({6'h0, chip_reset, warm_reset}, kind);
  endtask
  task automatic do_reset(input wdt_pkg::wdt_opt_t o);
    @(posedge sys_clk);
    reset_n  <= 1'b0;
    opt      <= o;
    sleeping <= 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs_timeout();
    do_reset(3'h6);
    rdc(8'h09, 8'h07);
    rdc(8'h0a, 8'h00);
    rdc(8'h33, 8'h00);
    wr(8'h0a, 8'hff);
    rdc(8'h0a, 8'h00);
    wr(8'h09, 8'hf8);
    rdc(8'h09, 8'hf8);
    pulse(4'h8);
    expect_to(1024, 8'h02);
    rdc(8'h0a, 8'h20);
    rdc(8'h09, 8'h07);
    chk({7'h0, irq}, 8'h00);       // masked out, no interrupt
    rdc(8'h20, 8'h01);
    wr(8'h09, 8'h01);
    pulse(4'h8);
    expect_to(2048, 8'h02);
    $display("test regs_timeout done");
  endtask
  task automatic t_single();
    wr(8'h09, 8'h00);
    pulse(4'h8);
    rdc(8'h0a, 8'h00);
    repeat (5) begin
      quiet(600);
      pulse(4'h8);
    end
    pulse(4'h4);
    pulse(4'h2);
    expect_to(1018, 8'h02);
    $display("test single_clear done");
  endtask
  task automatic t_pair();
    do_reset(3'h7);
    wr(8'h09, 8'h00);
    pulse(4'h4);
    pulse(4'h2);
    repeat (4) begin
      quiet(700);
      pulse(4'h2);
      pulse(4'h4);
    end
    pulse(4'h8);
    pulse(4'h4);
    expect_to(1020, 8'h02);
    $display("test pair_clear done");
  endtask
  task automatic t_sleep();
    do_reset(3'h6);
    wr(8'h09, 8'h00);
    wr(8'h21, 8'h02);
    rdc(8'h21, 8'h02);
    pulse(4'h1);
    sleeping <= 1'b1;
    expect_to(1022, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 chk({7'h0, irq}, 8'h01);
    rdc(8'h0a, 8'h30);
    rdc(8'h09, 8'h00);
    rdc(8'h20, 8'h02);
    repeat (2) @(posedge sys_clk);
    #1 chk({7'h0, irq}, 8'h00);
    $display("test sleep_wake done");
  endtask
  task automatic t_instr_off();
    do_reset(3'h4);
    wr(8'h09, 8'h00);
    pulse(4'h1);
    sleeping <= 1'b1;
    quiet(3000);
    @(posedge sys_clk);
    sleeping <= 1'b0;
    pulse(4'h8);
    expect_to(1024, 8'h02);
    do_reset(3'h2);
    wr(8'h09, 8'h00);
    quiet(3000);
    $display("test instr_and_disabled done");
  endtask
  // pin low mid-count restarts the count and the scale register
  task automatic t_pin();
    do_reset(3'h6);
    wr(8'h09, 8'h00);
    pulse(4'h8);
    quiet(500);
    @(posedge sys_clk);
    external_init_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    external_init_pin <= 1'b1;
    rdc(8'h09, 8'h07);
    wr(8'h09, 8'h00);
    expect_to(1022, 8'h02);
    $display("test reset_pin done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence, and a watchdog well past the expected run length
  initial begin
    t_regs_timeout();
    t_single();
    t_pair();
    t_sleep();
    t_instr_off();
    t_pin();
    results();
  end
  initial begin
    #900000;
    num_errors++;
    results();
  end
endmodule

//--- src/watchdog_timer.sv
// module: watchdog timer with prescaler, flags and register port
`timescale 1ns/1ps
module watchdog_timer (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // pins and oscillator
  input  wire logic             external_init_pin,
  input  wire logic             rc_osc_clk,
  // options and core strobes
  input  wire wdt_pkg::wdt_opt_t opt,
  input  wire wdt_pkg::wdt_cmd_t cmd,
  input  wire logic             sleeping,
  // register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_write,
  input  wire logic             reg_read,
  output logic      [7:0]       reg_rdata,
  // resets and interrupt
  output logic                  chip_reset,
  output logic                  warm_reset,
  output logic                  irq
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pin_sync;
  logic [1:0] rc_sync;
  logic       rc_prev;

  // both the reset pin and the rc oscillator are foreign to sys_clk
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_sync <= 2'h3;
      rc_sync  <= 2'h0;
      rc_prev  <= 1'b0;
    end else begin
      pin_sync <= {pin_sync[0], external_init_pin};
      rc_sync  <= {rc_sync[0], rc_osc_clk};
      rc_prev  <= rc_sync[1];
    end
  end

  wire pin_low = ~pin_sync[1];
  wire rc_tick = rc_sync[1] & ~rc_prev;

  // ---------------------------------------------------------------
  // tick source
  // ---------------------------------------------------------------
  logic [1:0] instr_cnt;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) instr_cnt <= 2'h0;
    else          instr_cnt <= instr_cnt + 2'h1;
  end

  wire instr_tick = (instr_cnt == wdt_pkg::instr_div_last);
  // rc keeps running in sleep; the instruction clock stops with it
  wire src_tick = opt.rc_source ? rc_tick
                                : instr_tick & ~sleeping;
  wire tick = opt.enable & src_tick;

  // ---------------------------------------------------------------
  // clear logic
  // ---------------------------------------------------------------
  logic first_seen;
  logic second_seen;

  // pair scheme: either order, both needed before the clear lands
  wire pair_done = (first_seen | cmd.clear_first) &
                   (second_seen | cmd.clear_second) &
                   (cmd.clear_first | cmd.clear_second);
  wire soft_clear = opt.pair_scheme ? pair_done
                                    : cmd.clear_single;
  wire sleep_cmd  = opt.enable & cmd.sleep_exec;
  wire single_cmd = opt.enable & ~opt.pair_scheme & cmd.clear_single;
  wire wdt_clear  = pin_low |
                    (opt.enable & (soft_clear | cmd.sleep_exec));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      first_seen  <= 1'b0;
      second_seen <= 1'b0;
    end else if (wdt_clear) begin
      first_seen  <= 1'b0;
      second_seen <= 1'b0;
    end else begin
      first_seen  <= first_seen | (opt.pair_scheme & cmd.clear_first);
      second_seen <= second_seen | (opt.pair_scheme & cmd.clear_second);
    end
  end

  // ---------------------------------------------------------------
  // divider chain
  // ---------------------------------------------------------------
  localparam int chain_w = wdt_pkg::base_stages + wdt_pkg::presc_stages;
  logic [chain_w-1:0] chain;
  logic [7:0]         scale_select;

  wire [2:0] sel = scale_select[wdt_pkg::sel_lsb +: wdt_pkg::sel_width];
  // terminal when base and selected prescaler stages are all ones
  wire [chain_w-1:0] term_mask =
    chain_w'((32'h1 << (wdt_pkg::base_stages + 32'(sel))) - 32'h1);
  wire at_term  = ((chain & term_mask) == term_mask);
  wire overflow = tick & at_term & ~wdt_clear;

  // a full count wraps to zero, so the next period starts clean
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)                  chain <= '0;
    else if (wdt_clear | overflow) chain <= '0;
    else if (tick)                 chain <= chain + chain_w'(1);
  end

  // ---------------------------------------------------------------
  // flags, scale register and reset outputs
  // ---------------------------------------------------------------
  logic expiry_flag;
  logic powerdown_flag;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  // address match shared by every register strobe
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] target);
    return addr == target;
  endfunction

  wire normal_ovf = overflow & ~sleeping;
  wire sleep_ovf  = overflow & sleeping;
  wire wr_scale = reg_write & reg_hit(reg_addr, wdt_pkg::scale_select_addr);
  wire wr_mask  = reg_write & reg_hit(reg_addr, wdt_pkg::irq_mask_addr);
  wire rd_irq   = reg_read & reg_hit(reg_addr, wdt_pkg::irq_status_addr);
  wire [1:0] irq_events = {sleep_ovf, normal_ovf};

  // flags ignore register writes; a clear in the same cycle masks the timeout
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      expiry_flag    <= 1'b0;
      powerdown_flag <= 1'b0;
    end else begin
      if (overflow)                      expiry_flag <= 1'b1;
      else if (single_cmd | sleep_cmd)   expiry_flag <= 1'b0;
      if (sleep_cmd)                     powerdown_flag <= 1'b1;
      else if (single_cmd)               powerdown_flag <= 1'b0;
    end
  end

  // scale register: low bits steer the prescaler, rest is user storage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)       scale_select <= wdt_pkg::scale_reset;
    else if (pin_low | normal_ovf) scale_select <= wdt_pkg::scale_reset;
    else if (wr_scale)  scale_select <= reg_wdata;
  end

  // one-cycle reset strobes toward the core
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      chip_reset <= 1'b0;
      warm_reset <= 1'b0;
    end else begin
      chip_reset <= normal_ovf;
      warm_reset <= sleep_ovf;
    end
  end

  // sticky status, cleared by a read; a new event wins over the read
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= 2'h0;
      irq_mask   <= 2'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (rd_irq ? 2'h0 : irq_status) | irq_events;
      if (wr_mask) irq_mask <= reg_wdata[1:0];
      irq <= |(((rd_irq ? 2'h0 : irq_status) | irq_events) & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      wdt_pkg::scale_select_addr: rd_mux = scale_select;
      wdt_pkg::flags_addr: begin
        rd_mux[wdt_pkg::expiry_bit]    = expiry_flag;
        rd_mux[wdt_pkg::powerdown_bit] = powerdown_flag;
      end
      wdt_pkg::irq_status_addr: rd_mux = {6'h00, irq_status};
      wdt_pkg::irq_mask_addr:   rd_mux = {6'h00, irq_mask};
      default:                  rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)      reg_rdata <= 8'h00;
    else if (reg_read) reg_rdata <= rd_mux;
    else               reg_rdata <= 8'h00;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // every check below lives in the sys_clk domain and sleeps in reset
  default clocking a_clk @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // pair scheme steps: one half arrives alone, the other half follows
  sequence s_first_half;
    opt.pair_scheme && cmd.clear_first && !cmd.clear_second && !wdt_clear;
  endsequence
  sequence s_second_half;
    opt.enable && cmd.clear_second;
  endsequence

  // a time-out while awake must reach the core and the expiry flag
  a_chip_reset_cause: assert property (
    normal_ovf |=> chip_reset && expiry_flag)
    else $error("normal overflow gave no chip reset");

  // the chip reset strobe is a single cycle wide
  a_chip_pulse_short: assert property (
    chip_reset |=> !chip_reset)
    else $error("chip reset strobe stuck high");

  // a time-out in sleep must never escalate to a full reset
  a_warm_reset_cause: assert property (
    sleep_ovf |=> warm_reset && !chip_reset)
    else $error("sleep overflow gave wrong reset");

  // warm reset leaves the scale register as software left it
  a_warm_keeps_scale: assert property (
    sleep_ovf && !pin_low && !wr_scale |=> $stable(scale_select))
    else $error("warm reset touched the scale register");

  // any accepted clear source restarts the whole chain
  a_clear_zeroes: assert property (
    wdt_clear |=> chain == '0)
    else $error("clear did not zero the chain");

  // sleep entry restarts the count, whichever source is chosen
  a_sleep_clears: assert property (
    opt.enable && cmd.sleep_exec |=> chain == '0)
    else $error("sleep did not clear the chain");

  // a disabled watchdog must not move, or it could fire later
  a_disabled_idle: assert property (
    !opt.enable && !pin_low |=> $stable(chain))
    else $error("disabled watchdog counted");

  // a disabled watchdog can never raise an overflow
  a_disabled_quiet: assert property (
    !opt.enable |-> !overflow)
    else $error("disabled watchdog overflowed");

  // the instruction clock stops in sleep, so the count freezes
  a_instr_sleep_hold: assert property (
    !opt.rc_source && sleeping && !wdt_clear |=> $stable(chain))
    else $error("instruction source counted in sleep");

  // the instruction tick comes once every four system clocks
  a_instr_spacing: assert property (
    instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick spacing wrong");

  // with the rc source, only rc edges may advance the chain
  a_rc_only_tick: assert property (
    opt.enable && opt.rc_source && !rc_tick && !wdt_clear
    |=> $stable(chain))
    else $error("chain moved without an rc edge");

  // the rc source keeps protecting the part while it sleeps
  a_rc_count_step: assert property (
    opt.enable && opt.rc_source && sleeping && rc_tick && !at_term &&
    !wdt_clear |=> chain == $past(chain) + chain_w'(1))
    else $error("rc source stalled in sleep");

  // the terminal count always includes a full base divider
  a_base_full: assert property (
    at_term |-> chain[wdt_pkg::base_stages-1:0] == 8'hff)
    else $error("terminal reached before base divider filled");

  // an overflow restarts the next period from zero
  a_wrap_zero: assert property (
    overflow |=> chain == '0)
    else $error("chain did not wrap after overflow");

  // the unselected single clear must not rescue a pair system
  a_single_ignored: assert property (
    opt.pair_scheme && cmd.clear_single && !cmd.clear_first &&
    !cmd.clear_second && !cmd.sleep_exec && !pin_low && chain != '0
    && !overflow |=> chain != '0)
    else $error("unselected clear acted");

  // pair instructions must not clear a single-scheme watchdog
  a_single_ignores_pair: assert property (
    !opt.pair_scheme && !cmd.clear_single && !cmd.sleep_exec && !pin_low
    |-> !wdt_clear)
    else $error("pair instruction cleared single scheme");

  // in the single scheme every single clear lands
  a_single_clears: assert property (
    opt.enable && !opt.pair_scheme && cmd.clear_single |=> chain == '0)
    else $error("single clear was lost");

  // half a pair alone is not enough to clear
  a_half_pair_held: assert property (
    opt.pair_scheme && cmd.clear_first && !cmd.clear_second &&
    !second_seen && !pin_low && !cmd.sleep_exec |-> !wdt_clear)
    else $error("half a pair cleared the watchdog");

  // the second half completes the pair and clears the chain
  a_pair_clear_done: assert property (
    s_first_half ##1 s_second_half |=> chain == '0)
    else $error("completed pair did not clear");

  // sleep marks power-down and drops the expiry flag
  a_sleep_flags: assert property (
    sleep_cmd && !overflow |=> powerdown_flag && !expiry_flag)
    else $error("sleep flags wrong");

  // a single clear drops both flags when nothing else competes
  a_flags_by_single: assert property (
    single_cmd && !overflow && !cmd.sleep_exec
    |=> !expiry_flag && !powerdown_flag)
    else $error("single clear left a flag set");

  // software cannot forge the cause of a reset by writing
  a_flags_write: assert property (
    reg_write && reg_hit(reg_addr, wdt_pkg::flags_addr) && !overflow &&
    !single_cmd && !sleep_cmd
    |=> $stable(expiry_flag) && $stable(powerdown_flag))
    else $error("register write changed a flag");

  // scale writes land whole, user bits included
  a_scale_store: assert property (
    wr_scale && !pin_low && !normal_ovf |=> scale_select == $past(reg_wdata))
    else $error("scale write lost");

  // a status read empties the sticky bits
  a_read_clear: assert property (
    rd_irq && irq_events == 2'h0 |=> irq_status == 2'h0)
    else $error("status read did not clear");

  // status bits stay until software reads them
  a_status_sticky: assert property (
    irq_status[0] && !rd_irq |=> irq_status[0])
    else $error("status bit lost before read");

endmodule

//--- src/wdt_pkg.sv
// package: constants and types for the watchdog timer with prescaler
package wdt_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] scale_select_addr = 8'h09;
  localparam logic [7:0] flags_addr        = 8'h0a; // expiry/pd flags
  localparam logic [7:0] irq_status_addr   = 8'h20;
  localparam logic [7:0] irq_mask_addr     = 8'h21;
  localparam logic [7:0] scale_reset       = 8'h07;
  localparam int         expiry_bit        = 5;
  localparam int         powerdown_bit     = 4;
  localparam int         sel_lsb           = 0;
  localparam int         sel_width         = 3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int         base_stages       = 8;   // divide by 256
  localparam int         presc_stages      = 7;   // up to 1:128
  localparam int         instr_div         = 4;   // sysclk / 4
  localparam logic [1:0] instr_div_last    = 2'h3;

  // interrupt status bits
  localparam int         irq_timeout_bit   = 0;
  localparam int         irq_warm_bit      = 1;

  // clear instruction strobes from the core
  typedef struct packed {
    logic clear_single;
    logic clear_first;
    logic clear_second;
    logic sleep_exec;
  } wdt_cmd_t;

  // build-time options
  typedef struct packed {
    logic enable;
    logic rc_source;
    logic pair_scheme;
  } wdt_opt_t;

endpackage
